/* File: design/spdma_top.sv */
// What this block does
// - Setting bit 0 of a channel command word starts it unless the channel is in reset, and bit 0 reads its run state.
// - Four ports each own an independent receive and transmit channel with its own run bit.
// - A transmit channel set to stop and interrupt halts and interrupts at terminal count.
// - A receive channel halts on end of process before terminal count, and interrupts only if its command word sets bit 10.
// - Command words 2402h and 2400h select stop and interrupt at terminal count.
// - Command word 4810h makes a receive channel stop and chain on end of process.
// - Count word 00FF0027h gives count 39 and 00FF0028h gives count 40, queuing off.
// - Software writes 0Fh to the interrupt mask word before starting transfers.
// - Writing 0 to a per-channel control stops that channel and its run bit reads 0.
// - Writing 1 to a stopped channel's control restarts it and its run bit reads 1.
// - Writing 2 to a per-channel control resets the channel and its run bit reads 0.
// - After a channel reset, writing 0 to the per-channel control leaves the reset state.
// - The global control stops and resets all channels and restarts those a stop paused, reflected in every run bit.
// - After a global reset every channel is stopped with its run bit at 0.
// - Global control codes are 1 stop, 0 restart, 2 reset, and a later 1 leaves reset.
//
// Purpose: Eight-channel DMA between local memory and a quad serial controller
// Assumes: Memory and serial handshakes are synchronous to ref_clk
// Notes:   Status bits are write-one-to-clear; mask bit p gates both channels of port p
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module spdma_top
  import spdma_pkg::*;
#(
  parameter int DW = 8
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic [SPDMA_AW-1:0]    reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  output logic                        irq,
  output logic                        mem_req,
  output logic                        mem_we,
  output logic [31:0]                 mem_addr,
  output logic [31:0]                 mem_wdata,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata,
  input  wire logic [SPDMA_CHANS-1:0] ser_req,
  input  wire logic [SPDMA_CHANS-1:0] end_of_process,
  input  wire logic [SPDMA_CHANS*DW-1:0] ser_rx_data,
  output logic [SPDMA_CHANS-1:0]      ser_ack,
  output logic [DW-1:0]               ser_tx_data,
  output logic [SPDMA_CHANS-1:0]      run_state
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [31:0]            channel_command_word [SPDMA_CHANS];
  logic [31:0]            count_and_queue_word [SPDMA_CHANS];
  logic [31:0]            mem_pointer          [SPDMA_CHANS];
  logic [31:0]            chain_pointer        [SPDMA_CHANS];
  logic [SPDMA_CHANS-1:0] run;
  logic [SPDMA_CHANS-1:0] paused;
  logic [SPDMA_CHANS-1:0] in_rst;
  logic [SPDMA_CHANS-1:0] int_status;
  logic [3:0]             interrupt_mask_word;
  logic [1:0]             global_dma_control;
  spdma_state_t           state;
  spdma_state_t           next_state;
  logic [2:0]             cur;
  logic [1:0]             desc_idx;
  logic [31:0]            next_rdata;

  // ------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------
  wire        chan_space = ~reg_addr[8];
  wire [2:0]  reg_chan   = reg_addr[7:5];
  wire [4:0]  reg_off    = reg_addr[4:0];
  wire        gctl_wr    = reg_wr && (reg_addr == SPDMA_ADR_GCTL);
  wire        mask_wr    = reg_wr && (reg_addr == SPDMA_ADR_MASK);
  wire        stat_wr    = reg_wr && (reg_addr == SPDMA_ADR_STAT);
  wire        g_stop     = gctl_wr && (reg_wdata == SPDMA_CODE_1);
  wire        g_restart  = gctl_wr && (reg_wdata == SPDMA_CODE_0);
  wire        g_reset    = gctl_wr && (reg_wdata == SPDMA_CODE_2);

  // ------------------------------------------------------------
  // Engine decisions for the channel in service
  // ------------------------------------------------------------
  wire [31:0] cur_cmd   = channel_command_word[cur];
  wire [15:0] cur_cnt   = count_and_queue_word[cur][15:0];
  wire        cur_tx    = cur_cmd[SPDMA_CMD_TX];
  wire        cur_chain = (chain_pointer[cur] != 32'h0000_0000);
  wire        hit_last  = (cur_cnt == SPDMA_CNT_END);
  wire        hit_end   = !cur_tx && end_of_process[cur];
  wire        chain_cnt = hit_last && cur_cmd[SPDMA_CMD_CHAIN_CNT] && cur_chain;
  wire        chain_end = hit_end && cur_cmd[SPDMA_CMD_CHAIN_END] && cur_chain;
  wire        eng_halt  = (hit_last && !chain_cnt) || hit_end;
  wire        eng_int   = (hit_last || hit_end) && cur_cmd[SPDMA_CMD_INT];
  wire        eng_fetch = chain_cnt || chain_end;
  wire        in_done   = (state == SPDMA_DONE);
  wire        fetch_ack = (state == SPDMA_FETCH) && mem_ack;

  // Channel may be served: running, controller ready, count left
  logic [SPDMA_CHANS-1:0] eligible;
  logic [SPDMA_CHANS-1:0] mask_ch;
  wire                    gnt_valid;
  wire  [2:0]             gnt_idx;
  wire                    take = (state == SPDMA_IDLE) && gnt_valid;

  // ------------------------------------------------------------
  // Per-channel registers and run control
  // ------------------------------------------------------------
  for (genvar g = 0; g < SPDMA_CHANS; g++) begin : g_ch
    wire sel     = chan_space && (reg_chan == 3'(g));
    wire cmd_wr  = reg_wr && sel && (reg_off == SPDMA_OFF_CMD);
    wire cnt_wr  = reg_wr && sel && (reg_off == SPDMA_OFF_CNT);
    wire mptr_wr = reg_wr && sel && (reg_off == SPDMA_OFF_MPTR);
    wire cptr_wr = reg_wr && sel && (reg_off == SPDMA_OFF_CPTR);
    wire dctl_wr = reg_wr && sel && (reg_off == SPDMA_OFF_DCTL);
    wire mine    = (cur == 3'(g));
    wire upd     = in_done && mine;
    wire ld      = fetch_ack && mine;
    wire d_zero  = dctl_wr && (reg_wdata == SPDMA_CODE_0);
    wire d_one   = dctl_wr && (reg_wdata == SPDMA_CODE_1);
    wire d_two   = dctl_wr && (reg_wdata == SPDMA_CODE_2);
    wire do_rst  = d_two || g_reset;
    wire do_stop = !in_rst[g] && (d_zero || g_stop);
    wire leave   = in_rst[g] && (d_zero || g_stop);
    wire do_rest = paused[g] && (d_one || g_restart);

    assign eligible[g] = run[g] && ser_req[g] && !in_rst[g] &&
                         (count_and_queue_word[g][15:0] != 16'h0000);
    assign mask_ch[g]  = interrupt_mask_word[g / 2];

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        channel_command_word[g] <= SPDMA_RST_WORD;
      end else if (cmd_wr) begin
        channel_command_word[g] <= reg_wdata;
      end else if (ld && desc_idx == 2'h0) begin
        channel_command_word[g] <= mem_rdata;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        count_and_queue_word[g] <= SPDMA_RST_WORD;
      end else if (cnt_wr) begin
        count_and_queue_word[g] <= reg_wdata;
      end else if (ld && desc_idx == 2'h1) begin
        count_and_queue_word[g] <= mem_rdata;
      end else if (upd) begin
        count_and_queue_word[g][15:0] <= cur_cnt - 16'h0001;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        mem_pointer[g] <= SPDMA_RST_WORD;
      end else if (mptr_wr) begin
        mem_pointer[g] <= reg_wdata;
      end else if (ld && desc_idx == 2'h2) begin
        mem_pointer[g] <= mem_rdata;
      end else if (upd) begin
        mem_pointer[g] <= mem_pointer[g] + SPDMA_MPTR_STEP;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        chain_pointer[g] <= SPDMA_RST_WORD;
      end else if (cptr_wr) begin
        chain_pointer[g] <= reg_wdata;
      end else if (ld && desc_idx == SPDMA_DESC_LAST) begin
        chain_pointer[g] <= mem_rdata;
      end
    end

    // Reset beats stop beats restart; a software start beats an engine halt
    always_ff @(posedge ref_clk) begin
      if (sys_rst || do_rst) begin
        run[g]    <= 1'b0;
        paused[g] <= 1'b0;
      end else if (do_stop) begin
        paused[g] <= run[g] || paused[g];
        run[g]    <= 1'b0;
      end else if (do_rest) begin
        run[g]    <= 1'b1;
        paused[g] <= 1'b0;
      end else if (cmd_wr && !in_rst[g]) begin
        run[g]    <= reg_wdata[SPDMA_CMD_RUN];
        paused[g] <= 1'b0;
      end else if (upd && eng_halt) begin
        run[g]    <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        in_rst[g] <= 1'b0;
      end else if (do_rst) begin
        in_rst[g] <= 1'b1;
      end else if (leave) begin
        in_rst[g] <= 1'b0;
      end
    end

    // New event wins over a same-cycle clear
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        int_status[g] <= 1'b0;
      end else if (upd && eng_int) begin
        int_status[g] <= 1'b1;
      end else if (stat_wr && reg_wdata[g]) begin
        int_status[g] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Global registers and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      interrupt_mask_word <= SPDMA_RST_MASK;
      global_dma_control  <= 2'h0;
    end else begin
      if (mask_wr) begin
        interrupt_mask_word <= reg_wdata[3:0];
      end
      if (gctl_wr) begin
        global_dma_control <= reg_wdata[1:0];
      end
    end
  end

  assign irq       = |(int_status & mask_ch);
  assign run_state = run;

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_addr == SPDMA_ADR_GCTL) begin
      next_rdata = {30'h0, global_dma_control};
    end else if (reg_addr == SPDMA_ADR_MASK) begin
      next_rdata = {28'h0, interrupt_mask_word};
    end else if (reg_addr == SPDMA_ADR_STAT) begin
      next_rdata = {24'h0, int_status};
    end else if (chan_space && reg_off == SPDMA_OFF_CMD) begin
      next_rdata = {channel_command_word[reg_chan][31:1], run[reg_chan]};
    end else if (chan_space && reg_off == SPDMA_OFF_CNT) begin
      next_rdata = count_and_queue_word[reg_chan];
    end else if (chan_space && reg_off == SPDMA_OFF_MPTR) begin
      next_rdata = mem_pointer[reg_chan];
    end else if (chan_space && reg_off == SPDMA_OFF_CPTR) begin
      next_rdata = chain_pointer[reg_chan];
    end else if (chan_space && reg_off == SPDMA_OFF_DCTL) begin
      next_rdata = {29'h0, in_rst[reg_chan], paused[reg_chan], run[reg_chan]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Transfer engine
  // ------------------------------------------------------------
  spdma_arb #(
    .N  (SPDMA_CHANS),
    .IW (3)
  ) u_arb (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .req       (eligible),
    .advance   (take),
    .gnt_valid (gnt_valid),
    .gnt_idx   (gnt_idx)
  );

  always_comb begin
    next_state = state;
    case (state)
      SPDMA_IDLE: begin
        if (gnt_valid) begin
          next_state = SPDMA_MEM;
        end
      end
      SPDMA_MEM: begin
        if (mem_ack) begin
          next_state = SPDMA_DONE;
        end
      end
      SPDMA_DONE: begin
        next_state = eng_fetch ? SPDMA_FETCH : SPDMA_IDLE;
      end
      SPDMA_FETCH: begin
        if (mem_ack && desc_idx == SPDMA_DESC_LAST) begin
          next_state = SPDMA_IDLE;
        end
      end
      default: begin
        next_state = SPDMA_IDLE;
      end
    endcase
  end

  assign mem_req = (state == SPDMA_MEM) || (state == SPDMA_FETCH);
  assign mem_we  = (state == SPDMA_MEM) && !cur_tx;
  assign ser_ack = in_done ? (SPDMA_CHANS'(1) << cur) : '0;

  // Descriptor words sit at consecutive words from the chain pointer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state       <= SPDMA_IDLE;
      cur         <= 3'h0;
      desc_idx    <= 2'h0;
      mem_addr    <= 32'h0000_0000;
      mem_wdata   <= 32'h0000_0000;
      ser_tx_data <= '0;
    end else begin
      state <= next_state;
      if (take) begin
        cur       <= gnt_idx;
        mem_addr  <= mem_pointer[gnt_idx];
        mem_wdata <= 32'(ser_rx_data[gnt_idx*DW +: DW]);
      end
      if (state == SPDMA_MEM && mem_ack && cur_tx) begin
        ser_tx_data <= mem_rdata[DW-1:0];
      end
      if (in_done && eng_fetch) begin
        desc_idx <= 2'h0;
        mem_addr <= chain_pointer[cur];
      end else if (fetch_ack) begin
        desc_idx <= desc_idx + 2'h1;
        mem_addr <= mem_addr + 32'h0000_0004;
      end
    end
  end
endmodule

/* File: design/spdma_pkg.sv */
// Purpose: Shared constants for the serial port DMA channel block
// Assumes: Byte register addresses on a 9-bit register port
// Notes:   Channel index is port*2 + direction (1 = transmit)
package spdma_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int SPDMA_PORTS   = 4;
  localparam int SPDMA_CHANS   = 8;
  localparam int SPDMA_AW      = 9;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [4:0] SPDMA_OFF_CMD   = 5'h00;
  localparam logic [4:0] SPDMA_OFF_CNT   = 5'h04;
  localparam logic [4:0] SPDMA_OFF_MPTR  = 5'h08;
  localparam logic [4:0] SPDMA_OFF_CPTR  = 5'h0c;
  localparam logic [4:0] SPDMA_OFF_DCTL  = 5'h10;
  localparam logic [8:0] SPDMA_ADR_GCTL  = 9'h100;
  localparam logic [8:0] SPDMA_ADR_MASK  = 9'h104;
  localparam logic [8:0] SPDMA_ADR_STAT  = 9'h108;

  // ------------------------------------------------------------
  // Command word fields
  // ------------------------------------------------------------
  localparam int SPDMA_CMD_RUN       = 0;
  localparam int SPDMA_CMD_TX        = 1;
  localparam int SPDMA_CMD_CHAIN_CNT = 7;
  localparam int SPDMA_CMD_INT       = 10;
  localparam int SPDMA_CMD_CHAIN_END = 14;

  // ------------------------------------------------------------
  // Control codes and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] SPDMA_CODE_0 = 32'h0000_0000;
  localparam logic [31:0] SPDMA_CODE_1 = 32'h0000_0001;
  localparam logic [31:0] SPDMA_CODE_2 = 32'h0000_0002;
  localparam logic [31:0] SPDMA_RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  SPDMA_RST_MASK = 4'h0;
  localparam logic [15:0] SPDMA_CNT_END  = 16'h0001;
  localparam logic [31:0] SPDMA_MPTR_STEP = 32'h0000_0001;
  localparam logic [1:0]  SPDMA_DESC_LAST = 2'h3;

  typedef enum logic [1:0] {
    SPDMA_IDLE  = 2'b00,
    SPDMA_MEM   = 2'b01,
    SPDMA_DONE  = 2'b11,
    SPDMA_FETCH = 2'b10
  } spdma_state_t;
endpackage

/* File: design/spdma_arb.sv */
// Purpose: Round-robin arbiter over channel service requests
// Assumes: advance pulses once per accepted grant
// Notes:   Search starts after the last granted index
`timescale 1ns/1ps
module spdma_arb #(
  parameter int N  = 8,
  parameter int IW = 3
) (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic [N-1:0]  req,
  input  wire logic          advance,
  output logic               gnt_valid,
  output logic [IW-1:0]      gnt_idx
);
  logic [IW-1:0] last;
  logic [IW-1:0] cand;

  always_comb begin
    gnt_valid = 1'b0;
    gnt_idx   = '0;
    cand      = '0;
    for (int i = 1; i <= N; i++) begin
      cand = IW'((int'(last) + i) % N);
      if (!gnt_valid && req[cand]) begin
        gnt_valid = 1'b1;
        gnt_idx   = cand;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      last <= IW'(N - 1);
    end else if (advance) begin
      last <= gnt_idx;
    end
  end
endmodule

/* File: tb/spdma_far.sv */
// Purpose: Far side model: local memory and quad serial controller
// Assumes: Memory byte at address a holds a[7:0]^5a
// Notes:   slow stretches the memory answer to at most four cycles
`timescale 1ns/1ps
module spdma_far
  import spdma_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   slow,
  input  wire logic [SPDMA_CHANS-1:0] ser_en,
  input  wire logic [SPDMA_CHANS-1:0] end_en,
  input  wire logic                   mem_req,
  input  wire logic [31:0]            mem_addr,
  input  wire logic [SPDMA_CHANS-1:0] ser_ack,
  output logic                        mem_ack,
  output logic [31:0]                 mem_rdata,
  output logic [SPDMA_CHANS-1:0]      ser_req,
  output logic [SPDMA_CHANS-1:0]      end_of_process,
  output logic [SPDMA_CHANS*8-1:0]    ser_rx_data
);
  logic [1:0] wait_cnt;
  logic [7:0] rx_cnt [SPDMA_CHANS];
  assign ser_req        = ser_en;
  assign end_of_process = end_en;
  always_ff @(posedge ref_clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata; // Garbage outside the answer cycle
    if (sys_rst) begin
      wait_cnt  <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack) begin
      if (wait_cnt == 2'h3 || !slow) begin
        mem_ack   <= 1'b1;
        mem_rdata <= {24'h0, mem_addr[7:0] ^ 8'h5a};
        wait_cnt  <= 2'h0;
      end else wait_cnt <= wait_cnt + 2'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < SPDMA_CHANS; c++) begin
      if (sys_rst) rx_cnt[c] <= 8'h0;
      else if (ser_ack[c]) rx_cnt[c] <= rx_cnt[c] + 8'h1;
    end
  end
  always_comb begin
    for (int c = 0; c < SPDMA_CHANS; c++) ser_rx_data[c*8+:8] = rx_cnt[c] ^ 8'(c << 5);
  end
endmodule

/* File: tb/spdma_sva.sv */
// Purpose: Port-level checker for the DMA channel block
// Assumes: One clock domain, synchronous reset
// Notes:   Run bits are watched only where a register write fixes them
`timescale 1ns/1ps
module spdma_sva
  import spdma_pkg::*;
(
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  input wire logic [SPDMA_AW-1:0]    reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  input wire logic                   irq,
  input wire logic                   mem_req,
  input wire logic                   mem_we,
  input wire logic [31:0]            mem_addr,
  input wire logic                   mem_ack,
  input wire logic [SPDMA_CHANS-1:0] ser_ack,
  input wire logic [SPDMA_CHANS-1:0] run_state
);
  logic [2:0] wr_ch;
  wire        dctl_wr = reg_wr && !reg_addr[8] && reg_addr[4:0] == SPDMA_OFF_DCTL;
  wire        gctl_wr = reg_wr && reg_addr == SPDMA_ADR_GCTL;
  always_ff @(posedge ref_clk) wr_ch <= reg_addr[7:5];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  ack_onehot_a: assert property ($onehot0(ser_ack))
    else $error("more than one channel acknowledged");
  ack_cause_a: assert property (ser_ack != 8'h0 |-> $past(mem_req) && $past(mem_ack))
    else $error("serial ack without finished memory access");
  ack_gap_a: assert property (ser_ack != 8'h0 |=> (ser_ack == 8'h0) [*2])
    else $error("transfers closer than allowed");
  req_hold_a: assert property (mem_req && !mem_ack |=>
      mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  mask_off_a: assert property (reg_wr && reg_addr == SPDMA_ADR_MASK
      && reg_wdata[3:0] == 4'h0 |=> !irq)
    else $error("interrupt with all ports masked");
  dctl_stop_a: assert property (dctl_wr && reg_wdata == SPDMA_CODE_0
      |=> !run_state[wr_ch])
    else $error("channel runs after stop");
  dctl_reset_a: assert property (dctl_wr && reg_wdata == SPDMA_CODE_2
      |=> !run_state[wr_ch])
    else $error("channel runs after reset");
  gctl_stop_a: assert property (gctl_wr && reg_wdata == SPDMA_CODE_1
      |=> run_state == 8'h00)
    else $error("channels run after global stop");
  gctl_reset_a: assert property (gctl_wr && reg_wdata == SPDMA_CODE_2
      |=> run_state == 8'h00)
    else $error("channels run after global reset");
endmodule
bind spdma_top spdma_sva spdma_sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .ser_ack(ser_ack), .run_state(run_state));

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the DMA channel block
// Assumes: Channel ch buffer at ch*0x100, memory model in spdma_far
// Notes:   Memory answer delay is randomised from an LFSR seeded with 8
`timescale 1ns/1ps
module tb
  import spdma_pkg::*;
;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic [8:0]  reg_addr = 9'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_wdata, mem_rdata, d;
  logic        irq, mem_req, mem_we, mem_ack;
  logic [7:0]  ser_req, end_of_process, ser_ack, run_state, ser_tx_data, st;
  logic [7:0]  ser_en = 8'h0, end_en = 8'h0;
  logic [63:0] ser_rx_data;
  logic [15:0] lfsr = 16'h0008;
  logic [31:0] cmdv [8];
  int          err_count = 0, total_checks = 0, cycles = 0, acks [8] = '{default: 0};
  spdma_top #(.DW(8)) spdma_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ser_req(ser_req),
    .end_of_process(end_of_process), .ser_rx_data(ser_rx_data), .ser_ack(ser_ack),
    .ser_tx_data(ser_tx_data), .run_state(run_state));
  spdma_far spdma_far_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .ser_en(ser_en),
    .end_en(end_en), .mem_req(mem_req), .mem_addr(mem_addr), .ser_ack(ser_ack),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ser_req(ser_req),
    .end_of_process(end_of_process), .ser_rx_data(ser_rx_data));
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [8:0] cadr(input int c, input logic [4:0] off);
    return 9'(c * 32) | {4'h0, off};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic rchk(input string nm, input logic [8:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(nm, e, v);
  endtask
  task automatic runs(input logic [7:0] e);
    for (int c = 0; c < 8; c++) begin
      rd(cadr(c, SPDMA_OFF_CMD), d);
      chk("run bit", {31'h0, e[c]}, {31'h0, d[0]});
    end
    #1 chk("run_state", {24'h0, e}, {24'h0, run_state});
  endtask
  task automatic cstep(input logic [8:0] a, input logic [31:0] v, input int c, input logic e);
    wr(a, v);
    rd(cadr(c, SPDMA_OFF_CMD), d);
    chk("run bit", {31'h0, e}, {31'h0, d[0]});
  endtask
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    lfsr <= lfsr_next(lfsr);
    slow <= lfsr[0];
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end
  // Reference model of each channel's byte stream
  always @(posedge ref_clk) if (!sys_rst) begin
    if (mem_req && mem_ack && mem_we) begin
      chk("rx address", {21'h0, mem_addr[10:8], 8'(acks[mem_addr[10:8]])}, mem_addr);
      chk("rx data", 32'(8'(acks[mem_addr[10:8]]) ^ {mem_addr[10:8], 5'h0}), mem_wdata);
    end
    for (int c = 0; c < 8; c++) if (ser_ack[c]) begin
      if (c % 2) chk("tx byte", {24'h0, 8'(acks[c]) ^ 8'h5a}, {24'h0, ser_tx_data});
      acks[c]++;
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int c;
    int n;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (c = 0; c < 8; c++) rchk("cmd reset", cadr(c, SPDMA_OFF_CMD), SPDMA_RST_WORD);
    rchk("mask reset", SPDMA_ADR_MASK, 32'h0);
    rchk("status reset", SPDMA_ADR_STAT, 32'h0);
    wr(9'h1fc, 32'hffff_ffff);
    rchk("unmapped", 9'h1fc, 32'h0);
    $display("test reset end");
    wr(SPDMA_ADR_MASK, 32'h0000_000f);
    rchk("mask", SPDMA_ADR_MASK, 32'h0000_000f);
    for (c = 0; c < 8; c++) begin
      cmdv[c] = (c % 2) ? 32'h0000_2402 : (c == 2) ? 32'h0000_4810 : 32'h0000_2400;
      wr(cadr(c, SPDMA_OFF_MPTR), 32'(c * 256));
      wr(cadr(c, SPDMA_OFF_CPTR), 32'h0);
      wr(cadr(c, SPDMA_OFF_CNT), (c % 2) ? 32'h00ff_0027 : 32'h00ff_0028);
      wr(cadr(c, SPDMA_OFF_CMD), cmdv[c]);
      rd(cadr(c, SPDMA_OFF_CNT), d);
      chk("count", (c % 2) ? 32'h27 : 32'h28, {16'h0, d[15:0]});
    end
    end_en <= 8'h54;
    ser_en <= 8'hff;
    for (c = 0; c < 8; c++) wr(cadr(c, SPDMA_OFF_CMD), cmdv[c] | 32'h1);
    for (c = 0; c < 5000 && run_state !== 8'h0; c++) @(posedge ref_clk);
    #1;
    for (c = 0; c < 8; c++) begin
      n = (c % 2) ? 39 : (c == 0) ? 40 : 1;
      st[c] = cmdv[c][SPDMA_CMD_INT];
      chk("transfers", 32'(n), 32'(acks[c]));
      rd(cadr(c, SPDMA_OFF_CNT), d);
      chk("count left", 32'(40 - n - (c % 2)), {16'h0, d[15:0]});
      rchk("pointer", cadr(c, SPDMA_OFF_MPTR), 32'(c * 256 + n));
    end
    runs(8'h00);
    rchk("status", SPDMA_ADR_STAT, {24'h0, st});
    chk("irq", 32'h1, {31'h0, irq});
    wr(SPDMA_ADR_MASK, 32'h2);
    chk("irq port1", 32'h1, {31'h0, irq});
    wr(SPDMA_ADR_STAT, 32'h08);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rchk("status w1c", SPDMA_ADR_STAT, {24'h0, st & 8'hf7});
    $display("test transfer end");
    ser_en <= 8'h0;
    for (c = 0; c < 8; c++) begin
      wr(cadr(c, SPDMA_OFF_CNT), 32'h00ff_0028);
      wr(cadr(c, SPDMA_OFF_CMD), cmdv[c] | 32'h1);
    end
    runs(8'hff);
    for (c = 0; c < 8; c++) begin
      cstep(cadr(c, SPDMA_OFF_DCTL), SPDMA_CODE_0, c, 1'b0);
      cstep(cadr(c, SPDMA_OFF_DCTL), SPDMA_CODE_1, c, 1'b1);
      cstep(cadr(c, SPDMA_OFF_DCTL), SPDMA_CODE_2, c, 1'b0);
    end
    for (c = 0; c < 8; c++) wr(cadr(c, SPDMA_OFF_DCTL), SPDMA_CODE_0);
    for (c = 0; c < 8; c++) wr(cadr(c, SPDMA_OFF_CMD), cmdv[c] | 32'h1);
    runs(8'hff);
    $display("test channel control end");
    wr(SPDMA_ADR_GCTL, SPDMA_CODE_1);
    runs(8'h00);
    wr(SPDMA_ADR_GCTL, SPDMA_CODE_0);
    runs(8'hff);
    wr(SPDMA_ADR_GCTL, SPDMA_CODE_2);
    runs(8'h00);
    cstep(cadr(0, SPDMA_OFF_CMD), cmdv[0] | 32'h1, 0, 1'b0);
    wr(SPDMA_ADR_GCTL, SPDMA_CODE_1);
    cstep(cadr(0, SPDMA_OFF_CMD), cmdv[0] | 32'h1, 0, 1'b1);
    wr(SPDMA_ADR_MASK, 32'h0);
    wr(SPDMA_ADR_STAT, 32'hff);
    rchk("status clear", SPDMA_ADR_STAT, 32'h0);
    $display("test global control end");
    conclude();
  end
endmodule
